// [inc/brl_pkg.sv]
`default_nettype none
package brl_pkg;
    localparam int unsigned CLK_HZ = 125000000;
    localparam int unsigned BAUD_RATE = 9600;
    localparam int unsigned BIT_CYC = CLK_HZ / BAUD_RATE;
    localparam logic [15:0] BIT_CYC_W = 16'(BIT_CYC);
    localparam logic [15:0] HALF_CYC_W = 16'(BIT_CYC / 2);
    localparam logic [3:0] DATA_BITS = 4'h8;
    localparam logic [7:0] CHAR_KEEP_MIN = 8'h30;
    localparam logic [7:0] CHAR_CR = 8'h0D;
    localparam logic [3:0] ADDR_DIGITS = 4'hA;
    localparam logic [31:0] RESUME_ADDR = 32'hFFFFFF44;
    localparam logic [31:0] IBUF_ADDR = 32'hFFFFFFAA;
    localparam logic [2:0] IBUF_LAST = 3'h7;
    localparam logic [7:0] EXEC_COUNT = 8'h00;
    typedef enum logic [1:0] {BRL_IDLE, BRL_START, BRL_DATA, BRL_STOP} brl_uart_t;
    typedef enum logic [1:0] {BRL_BOOT, BRL_RUN_IBUF, BRL_RUN_USER} brl_mode_t;
endpackage
`default_nettype wire

// [inc/brl_char_if.sv]
`default_nettype none
interface brl_char_if;
    logic valid;
    logic [7:0] data;
    logic busy;
    modport src (output valid, output data, input busy);
    modport dst (input valid, input data, output busy);
endinterface
`default_nettype wire

// [design/brl_uart_rx.sv]
`default_nettype none
module brl_uart_rx
    import brl_pkg::*;
(
    input wire logic ref_clk, // system clock
    input wire logic sys_rst, // sync reset
    input wire logic rxd, // serial in, async
    brl_char_if.src ch // received characters
);
    parameter logic [15:0] BIT_CYC_P = BIT_CYC_W; // clocks per bit, 9600 baud by default
    localparam logic [15:0] HALF_P = BIT_CYC_P >> 1;
    typedef struct packed {
        logic [2:0] sync;
        logic ln; // filtered line level
        brl_uart_t st;
        logic [15:0] cnt;
        logic [3:0] bitn;
        logic [7:0] sh;
        logic valid;
        logic [7:0] data;
    } brl_rx_t;
    brl_rx_t r, next_r;
    logic line;
    // sync[1] and sync[2] must agree before a change counts
    always_comb begin
        next_r = r;
        next_r.sync = {r.sync[1:0], rxd};
        next_r.valid = 1'b0;
        next_r.ln = (r.sync[2] == r.sync[1]) ? r.sync[2] : r.ln;
        line = r.ln;
        unique case (r.st)
            BRL_IDLE: if (!line) begin
                next_r.st = BRL_START;
                next_r.cnt = HALF_P;
            end
            BRL_START: if (r.cnt == 16'h0000) begin
                next_r.st = line ? BRL_IDLE : BRL_DATA;
                next_r.cnt = BIT_CYC_P - 16'h0001;
                next_r.bitn = 4'h0;
            end else next_r.cnt = r.cnt - 16'h0001;
            BRL_DATA: if (r.cnt == 16'h0000) begin
                next_r.sh = {line, r.sh[7:1]}; // lsb first
                next_r.cnt = BIT_CYC_P - 16'h0001; // count to zero makes one bit time
                next_r.bitn = r.bitn + 4'h1;
                if (r.bitn == DATA_BITS - 4'h1) next_r.st = BRL_STOP;
            end else next_r.cnt = r.cnt - 16'h0001;
            BRL_STOP: if (r.cnt == 16'h0000) begin
                next_r.st = BRL_IDLE;
                next_r.valid = line; // framing error drops char
                next_r.data = r.sh;
            end else next_r.cnt = r.cnt - 16'h0001;
        endcase
    end
    always_ff @(posedge ref_clk) begin
        if (sys_rst) r <= '{sync: 3'h7, st: BRL_IDLE, ln: 1'b1, default: '0};
        else r <= next_r;
    end
    assign ch.valid = r.valid;
    assign ch.data = r.data;
endmodule
`default_nettype wire

// [design/brl_uart_tx.sv]
`default_nettype none
module brl_uart_tx
    import brl_pkg::*;
(
    input wire logic ref_clk, // system clock
    input wire logic sys_rst, // sync reset
    brl_char_if.dst ch, // characters to echo
    output logic txd // serial out
);
    parameter logic [15:0] BIT_CYC_P = BIT_CYC_W; // clocks per bit, 9600 baud by default
    typedef struct packed {
        logic busy;
        logic [15:0] cnt;
        logic [3:0] bitn;
        logic [9:0] sh;
    } brl_tx_t;
    brl_tx_t r, next_r;
    // start, 8 data, 1 stop; no parity
    always_comb begin
        next_r = r;
        if (!r.busy) begin
            if (ch.valid) begin
                next_r.busy = 1'b1;
                next_r.sh = {1'b1, ch.data, 1'b0};
                next_r.cnt = BIT_CYC_P;
                next_r.bitn = 4'h0;
            end
        end else if (r.cnt == 16'h0001) begin
            next_r.cnt = BIT_CYC_P;
            next_r.sh = {1'b1, r.sh[9:1]};
            next_r.bitn = r.bitn + 4'h1;
            if (r.bitn == 4'h9) next_r.busy = 1'b0;
        end else next_r.cnt = r.cnt - 16'h0001;
    end
    always_ff @(posedge ref_clk) begin
        if (sys_rst) r <= '{sh: 10'h3FF, default: '0};
        else r <= next_r;
    end
    assign txd = r.busy ? r.sh[0] : 1'b1;
    assign ch.busy = r.busy;
endmodule
`default_nettype wire

// [design/brl_loader.sv]
`default_nettype none
// Behaviour
// - non-hex character starts a fresh record
// - echo every received character back
// - keep only characters at or above 0x30
// - character below 0x30 ends current record
// - count 00 record executes at address
// - jump to FFFFFF44 resumes bootstrap
// - no backspace; carriage return ends record
// - stay in bootstrap until execution record
// - execute at FFFFFFAA runs buffered instruction
// - in bootstrap, reset and A-line vector reads return loader-supplied data
// - only receive and transmit lines used
// - serial link at 9600 8N1
// - address, count, then count data bytes
// - one byte write per data byte
module brl_loader
    import brl_pkg::*;
(
    input wire logic ref_clk, // 125 MHz system clock
    input wire logic sys_rst, // synchronous reset, high
    input wire logic bootstrap_break_input, // low at reset selects bootstrap
    input wire logic rxd, // serial receive
    output logic txd, // serial transmit
    output logic wr_en, // byte write strobe
    output logic [31:0] wr_addr, // byte write address
    output logic [7:0] wr_data, // byte write data
    output logic exec_en, // pass control strobe
    output logic [31:0] exec_addr, // execution target
    output logic boot_mode, // bootstrap operation active
    output logic ibuf_run, // instruction buffer running
    input wire logic ibuf_done, // buffered instruction finished
    input wire logic jump_valid, // core jump strobe
    input wire logic [31:0] jump_addr, // core jump target
    input wire logic vec_rd, // core vector-space read
    input wire logic [31:0] vec_addr, // vector read address
    output logic vec_hit, // loader supplies read data
    output logic [31:0] vec_rdata // loader-supplied vector data
);
    parameter logic [31:0] BOOT_SP = 32'h00000000; // arbitrary loader stack
    parameter logic [31:0] BOOT_PC = 32'hFFFFFF44; // arbitrary loader entry
    parameter logic [15:0] BIT_CYC_P = BIT_CYC_W; // clocks per bit; shorter only to speed up tests

    brl_char_if rx_ch();
    brl_char_if tx_ch();

    // only rxd and txd carry the link
    brl_uart_rx #(.BIT_CYC_P(BIT_CYC_P)) u_rx (
        .ref_clk(ref_clk),
        .sys_rst(sys_rst),
        .rxd(rxd),
        .ch(rx_ch.src)
    );
    brl_uart_tx #(.BIT_CYC_P(BIT_CYC_P)) u_tx (
        .ref_clk(ref_clk),
        .sys_rst(sys_rst),
        .ch(tx_ch.dst),
        .txd(txd)
    );

    typedef struct packed {
        logic strap_seen;
        brl_mode_t mode;
        logic [3:0] ndig; // address+count digits held
        logic [39:0] hdr;
        logic hi_have;
        logic [3:0] hi;
        logic [7:0] left;
        logic [31:0] ptr;
        logic wr;
        logic [31:0] waddr;
        logic [7:0] wdata;
        logic ex;
        logic [31:0] eaddr;
        logic [7:0] echo;
        logic echo_pend;
    } brl_st_t;
    brl_st_t r, next_r;

    logic c_valid;
    logic [7:0] c;
    logic is_hex;
    logic [3:0] nib;
    logic [7:0] byte_v;
    assign c_valid = rx_ch.valid;
    assign c = rx_ch.data;

    // uppercase hex digit decode
    always_comb begin
        is_hex = 1'b1;
        nib = 4'h0;
        if (c >= 8'h30 && c <= 8'h39) nib = 4'(c - 8'h30);
        else if (c >= 8'h41 && c <= 8'h46) nib = 4'(c - 8'h37);
        else is_hex = 1'b0;
    end
    assign byte_v = {r.hi, nib};

    always_comb begin
        next_r = r;
        next_r.wr = 1'b0;
        next_r.ex = 1'b0;
        // echo holds one char; the rx gap covers tx time at same baud
        if (c_valid) begin
            next_r.echo = c;
            next_r.echo_pend = 1'b1;
        end else if (r.echo_pend && !tx_ch.busy) next_r.echo_pend = 1'b0;
        // strap caught on first clock after reset release
        if (!r.strap_seen) begin
            next_r.strap_seen = 1'b1;
            next_r.mode = bootstrap_break_input ? BRL_RUN_USER : BRL_BOOT;
        end
        unique case (r.mode)
            BRL_BOOT: if (c_valid) begin
                if (c < CHAR_KEEP_MIN || c == CHAR_CR || !is_hex) begin
                    next_r.ndig = 4'h0;
                    next_r.hi_have = 1'b0;
                    next_r.left = 8'h00;
                end else if (r.ndig != ADDR_DIGITS) begin
                    next_r.hdr = {r.hdr[35:0], nib};
                    next_r.ndig = r.ndig + 4'h1;
                    if (r.ndig == ADDR_DIGITS - 4'h1) begin
                        next_r.left = {r.hdr[3:0], nib};
                        next_r.ptr = r.hdr[35:4];
                    end
                end else if (!r.hi_have) begin
                    next_r.hi_have = 1'b1;
                    next_r.hi = nib;
                end else begin
                    next_r.hi_have = 1'b0;
                    if (r.left != 8'h00) begin
                        next_r.wr = 1'b1;
                        next_r.waddr = r.ptr;
                        next_r.wdata = byte_v;
                        next_r.ptr = r.ptr + 32'h00000001;
                        next_r.left = r.left - 8'h01;
                    end
                end
            end
            BRL_RUN_IBUF: if (ibuf_done) next_r.mode = BRL_BOOT;
            BRL_RUN_USER: if (jump_valid && jump_addr == RESUME_ADDR) begin
                next_r.mode = BRL_BOOT;
                next_r.ndig = 4'h0;
                next_r.hi_have = 1'b0;
            end
            default: next_r.mode = BRL_BOOT;
        endcase
        // execution record accepted on its terminator
        if (r.mode == BRL_BOOT && c_valid && (c < CHAR_KEEP_MIN || c == CHAR_CR || !is_hex)
            && r.ndig == ADDR_DIGITS && r.hdr[7:0] == EXEC_COUNT && !r.hi_have) begin
            next_r.ex = 1'b1;
            next_r.eaddr = r.hdr[39:8];
            next_r.mode = (r.hdr[39:8] == IBUF_ADDR) ? BRL_RUN_IBUF : BRL_RUN_USER;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (sys_rst) r <= '{mode: BRL_BOOT, default: '0};
        else r <= next_r;
    end

    assign tx_ch.valid = r.echo_pend && !tx_ch.busy;
    assign tx_ch.data = r.echo;
    assign wr_en = r.wr;
    assign wr_addr = r.waddr;
    assign wr_data = r.wdata;
    assign exec_en = r.ex;
    assign exec_addr = r.eaddr;
    assign boot_mode = (r.mode != BRL_RUN_USER);
    assign ibuf_run = (r.mode == BRL_RUN_IBUF);

    // in bootstrap, reset and A-line vectors come from the loader
    always_comb begin
        vec_hit = 1'b0;
        vec_rdata = 32'h00000000;
        if (boot_mode && vec_rd) begin
            if (vec_addr <= 32'h00000003) begin
                vec_hit = 1'b1;
                vec_rdata = BOOT_SP;
            end else if (vec_addr <= 32'h00000007) begin
                vec_hit = 1'b1;
                vec_rdata = BOOT_PC;
            end else if (vec_addr >= 32'h00000028 && vec_addr <= 32'h0000002B) begin
                vec_hit = 1'b1;
                vec_rdata = BOOT_PC;
            end
        end
    end

    chk_echo_taken: assert property (@(posedge ref_clk) disable iff (sys_rst)
        c_valid |=> r.echo_pend && r.echo == $past(c)) else $error("char not queued for echo");
    chk_low_char_restart: assert property (@(posedge ref_clk) disable iff (sys_rst)
        (c_valid && c < CHAR_KEEP_MIN && r.mode == BRL_BOOT) |=> r.ndig == 4'h0) else $error("no restart");
    chk_nonhex_restart: assert property (@(posedge ref_clk) disable iff (sys_rst)
        (c_valid && !is_hex && r.mode == BRL_BOOT) |=> !r.hi_have && r.left == 8'h00) else $error("nonhex kept");
    chk_short_no_exec: assert property (@(posedge ref_clk) disable iff (sys_rst)
        (c_valid && r.ndig != ADDR_DIGITS) |=> !exec_en) else $error("short record executed");
    chk_write_in_boot: assert property (@(posedge ref_clk) disable iff (sys_rst)
        wr_en |-> $past(r.mode) == BRL_BOOT && $past(r.left) != 8'h00) else $error("bad write");
    chk_write_addr_step: assert property (@(posedge ref_clk) disable iff (sys_rst)
        wr_en |-> r.ptr == wr_addr + 32'h00000001) else $error("write address not stepped");
    chk_ibuf_exec: assert property (@(posedge ref_clk) disable iff (sys_rst)
        (exec_en && exec_addr == IBUF_ADDR) |-> ibuf_run) else $error("ibuf not run");
    chk_resume_jump: assert property (@(posedge ref_clk) disable iff (sys_rst)
        (r.mode == BRL_RUN_USER && jump_valid && jump_addr == RESUME_ADDR) |=> boot_mode) else $error("no resume");
    chk_stay_boot: assert property (@(posedge ref_clk) disable iff (sys_rst)
        ($fell(boot_mode) && $past(r.strap_seen)) |-> exec_en) else $error("left boot");
    chk_vector_hit: assert property (@(posedge ref_clk) disable iff (sys_rst)
        (boot_mode && vec_rd && vec_addr == 32'h00000029) |-> vec_hit) else $error("vector miss");
    // echo launch: start bit follows the handoff
    chk_echo_start: assert property (@(posedge ref_clk) disable iff (sys_rst)
        tx_ch.valid |=> !txd
    ) else $error("echo not started");
    // kept digits grow the header by one
    chk_keep_hex: assert property (@(posedge ref_clk) disable iff (sys_rst)
        (c_valid && is_hex && r.mode == BRL_BOOT && r.ndig != ADDR_DIGITS) |=> r.ndig == $past(r.ndig) + 4'h1
    ) else $error("digit not kept");
    // digit lands in low nibble of header
    chk_hdr_shift: assert property (@(posedge ref_clk) disable iff (sys_rst)
        (c_valid && is_hex && r.mode == BRL_BOOT && r.ndig != ADDR_DIGITS) |=> r.hdr[3:0] == $past(nib)
    ) else $error("header digit lost");
    // carriage return drops partial record
    chk_cr_restart: assert property (@(posedge ref_clk) disable iff (sys_rst)
        (c_valid && c == CHAR_CR && r.mode == BRL_BOOT) |=> r.ndig == 4'h0
    ) else $error("cr kept record");
    // low characters never cause a write
    chk_low_no_write: assert property (@(posedge ref_clk) disable iff (sys_rst)
        (c_valid && c < CHAR_KEEP_MIN) |=> !wr_en
    ) else $error("low char wrote");
    // execution needs full header with count 00
    chk_exec_count: assert property (@(posedge ref_clk) disable iff (sys_rst)
        exec_en |-> $past(r.hdr[7:0]) == EXEC_COUNT && $past(r.ndig) == ADDR_DIGITS
    ) else $error("exec without zero count");
    // execution target is the record address
    chk_exec_addr: assert property (@(posedge ref_clk) disable iff (sys_rst)
        exec_en |-> exec_addr == $past(r.hdr[39:8])
    ) else $error("exec address wrong");
    // execution strobe is one cycle
    chk_exec_pulse: assert property (@(posedge ref_clk) disable iff (sys_rst)
        exec_en |=> !exec_en
    ) else $error("exec strobe stuck");
    // user program leaves bootstrap at once
    chk_exec_leaves: assert property (@(posedge ref_clk) disable iff (sys_rst)
        (exec_en && exec_addr != IBUF_ADDR) |-> !boot_mode
    ) else $error("still in bootstrap");
    // no writes while a program runs
    chk_no_write_user: assert property (@(posedge ref_clk) disable iff (sys_rst)
        (r.mode != BRL_BOOT) |=> !wr_en
    ) else $error("write outside bootstrap");
    // buffer run lasts until done
    chk_ibuf_hold: assert property (@(posedge ref_clk) disable iff (sys_rst)
        (ibuf_run && !ibuf_done) |=> ibuf_run
    ) else $error("buffer run cut short");
    // buffer done returns to record intake
    chk_ibuf_return: assert property (@(posedge ref_clk) disable iff (sys_rst)
        (ibuf_run && ibuf_done) |=> !ibuf_run && boot_mode
    ) else $error("no return from buffer");
    // resume starts a clean record
    chk_resume_clear: assert property (@(posedge ref_clk) disable iff (sys_rst)
        (r.mode == BRL_RUN_USER && jump_valid && jump_addr == RESUME_ADDR) |=> r.ndig == 4'h0
    ) else $error("resume kept record");
    // vectors belong to memory outside bootstrap
    chk_vec_user_miss: assert property (@(posedge ref_clk) disable iff (sys_rst)
        !boot_mode |-> !vec_hit
    ) else $error("vector hit outside bootstrap");
    // write strobe is one cycle
    chk_strobe_pulse: assert property (@(posedge ref_clk) disable iff (sys_rst)
        wr_en |=> !wr_en
    ) else $error("write strobe stuck");
    // each write uses up one count
    chk_count_step: assert property (@(posedge ref_clk) disable iff (sys_rst)
        wr_en |-> r.left == $past(r.left) - 8'h01
    ) else $error("count not stepped");
    // written byte is upper then lower nibble
    chk_write_data: assert property (@(posedge ref_clk) disable iff (sys_rst)
        wr_en |-> wr_data == {$past(r.hi), $past(nib)}
    ) else $error("byte pairing wrong");
    // lone nibble is held, not written
    chk_odd_nibble: assert property (@(posedge ref_clk) disable iff (sys_rst)
        (c_valid && is_hex && r.mode == BRL_BOOT && r.ndig == ADDR_DIGITS && !r.hi_have) |=> r.hi_have && !wr_en
    ) else $error("nibble not held");
    // header still open means no write
    chk_short_no_write: assert property (@(posedge ref_clk) disable iff (sys_rst)
        (c_valid && r.mode == BRL_BOOT && r.ndig != ADDR_DIGITS) |=> !wr_en
    ) else $error("short record wrote");

    // main scenarios
    cov_data_write: cover property (@(posedge ref_clk) disable iff (sys_rst) wr_en);
    cov_resume: cover property (@(posedge ref_clk) disable iff (sys_rst) $rose(boot_mode));
    cov_exec_user: cover property (@(posedge ref_clk) disable iff (sys_rst) exec_en && !ibuf_run);
    cov_exec_ibuf: cover property (@(posedge ref_clk) disable iff (sys_rst) exec_en && ibuf_run);
endmodule
`default_nettype wire

// [verif/brl_host_term.sv]
`default_nettype none
module brl_host_term
    import brl_pkg::*;
#(
    parameter int BIT_T = BIT_CYC // clocks per bit
)
(
    input wire logic ref_clk, // system clock
    output logic rxd, // line toward the device
    input wire logic txd // echo line from the device
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] echo_q[$]; // characters heard back
    logic [7:0] sh;
    initial rxd = 1'b1; // mark idle, no handshake lines exist

    // 8N1 frame, lsb first; host sends any character, including G, space and CR
    task automatic send_char(input logic [7:0] c);
        logic [9:0] fr;
        fr = {1'b1, c, 1'b0};
        for (int i = 0; i < 10; i++) begin
            rxd <= fr[i];
            repeat (BIT_T) @(posedge ref_clk);
        end
    endtask

    // mid-bit sampling of echoes; a bad stop bit corrupts the byte
    always begin
        @(posedge ref_clk iff txd === 1'b0);
        repeat (BIT_T / 2) @(posedge ref_clk);
        for (int i = 0; i < 8; i++) begin
            repeat (BIT_T) @(posedge ref_clk);
            sh[i] = txd;
        end
        repeat (BIT_T) @(posedge ref_clk);
        echo_q.push_back(txd === 1'b1 ? sh : 8'hXX);
    end
endmodule
`default_nettype wire

// [verif/tb_top.sv]
`default_nettype none
module tb_top;
    import brl_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;
    // short bit time keeps the run small; one char is ten bit times
    localparam int BIT_T = 64;
    localparam logic [15:0] BIT_W = 16'h0040;
    localparam int WATCH = 80 * 10 * BIT_T;
    logic ref_clk, sys_rst, brk, rxd, txd, wr_en, exec_en, boot_mode, ibuf_run;
    logic ibuf_done, jump_valid, vec_rd, vec_hit;
    logic [31:0] wr_addr, exec_addr, jump_addr, vec_addr, vec_rdata;
    logic [7:0] wr_data;
    logic [39:0] wr_q[$];
    logic [31:0] ex_q[$];
    int mismatches = 0;
    int total_checks = 0;

    initial begin
        ref_clk = 1'b0;
        forever #4 ref_clk = ~ref_clk;
    end

    brl_loader #(.BIT_CYC_P(BIT_W)) brl_loader_i (.ref_clk(ref_clk), .sys_rst(sys_rst), .bootstrap_break_input(brk),
        .rxd(rxd), .txd(txd), .wr_en(wr_en), .wr_addr(wr_addr), .wr_data(wr_data),
        .exec_en(exec_en), .exec_addr(exec_addr), .boot_mode(boot_mode), .ibuf_run(ibuf_run),
        .ibuf_done(ibuf_done), .jump_valid(jump_valid), .jump_addr(jump_addr), .vec_rd(vec_rd),
        .vec_addr(vec_addr), .vec_hit(vec_hit), .vec_rdata(vec_rdata));
    brl_host_term #(.BIT_T(BIT_T)) brl_host_term_i (.ref_clk(ref_clk), .rxd(rxd), .txd(txd));

    // strobes last one cycle, so log them at every edge
    always @(posedge ref_clk) begin
        if (wr_en === 1'b1) wr_q.push_back({wr_addr, wr_data});
        if (exec_en === 1'b1) ex_q.push_back(exec_addr);
    end

    task automatic chk_val(input string what, input logic [31:0] exp, input logic [31:0] got);
        total_checks++;
        if (got !== exp) begin
            mismatches++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic chk_bit(input string what, input logic exp, input logic got);
        total_checks++;
        if (got !== exp) begin
            mismatches++;
            $display("Error %s expected %b seen %b", what, exp, got);
        end
    endtask

    task automatic give_verdict();
        $display("checks %0d mismatches %0d", total_checks, mismatches);
        if (mismatches == 0 && total_checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    // send a string, then wait for the last echo under a bound
    task automatic send_str(input string s);
        int n;
        n = brl_host_term_i.echo_q.size();
        for (int i = 0; i < s.len(); i++) brl_host_term_i.send_char(s[i]);
        for (int w = 0; w < 12 * BIT_T && brl_host_term_i.echo_q.size() < n + s.len(); w++)
            @(posedge ref_clk);
        for (int i = 0; i < s.len(); i++)
            chk_val("echo", 32'(s[i]), 32'(brl_host_term_i.echo_q[n + i]));
    endtask

    task automatic vec_probe(input logic [31:0] a, input logic exp);
        @(posedge ref_clk);
        vec_addr <= a;
        @(negedge ref_clk);
        chk_bit("vec_hit", exp, vec_hit);
        @(posedge ref_clk);
    endtask

    task automatic t_reset();
        logic [31:0] va[6] = '{32'h0, 32'h7, 32'h28, 32'h2B, 32'h8, 32'h2C};
        chk_bit("boot_mode", 1'b1, boot_mode);
        chk_bit("txd idle", 1'b1, txd);
        vec_rd <= 1'b1;
        for (int i = 0; i < 6; i++) vec_probe(va[i], i < 4);
        vec_rd <= 1'b0;
        $display("test reset done");
    endtask

    // two bytes whose nibbles swap if digit pairing is reversed
    task automatic t_data();
        wr_q.delete();
        send_str("0000400102A55A\015");
        chk_val("writes", 32'h2, 32'(wr_q.size()));
        chk_val("wr_addr0", 32'h00004001, wr_q[0][39:8]);
        chk_val("wr_data0", 32'hA5, 32'(wr_q[0][7:0]));
        chk_val("wr_addr1", 32'h00004002, wr_q[1][39:8]);
        chk_val("wr_data1", 32'h5A, 32'(wr_q[1][7:0]));
        chk_bit("boot_mode", 1'b1, boot_mode);
        $display("test data done");
    endtask

    // letter G and a space each restart; a short record is dropped
    task automatic t_discard();
        wr_q.delete();
        ex_q.delete();
        send_str("7G12 0000500001C3\015123\015");
        chk_val("writes", 32'h1, 32'(wr_q.size()));
        chk_val("wr_addr", 32'h00005000, wr_q[0][39:8]);
        chk_val("wr_data", 32'hC3, 32'(wr_q[0][7:0]));
        chk_val("execs", 32'h0, 32'(ex_q.size()));
        $display("test discard done");
    endtask

    task automatic t_ibuf();
        ex_q.delete();
        wr_q.delete();
        send_str("FFFFFFAA00\015");
        chk_val("exec_addr", 32'hFFFFFFAA, ex_q[0]);
        chk_val("writes", 32'h0, 32'(wr_q.size()));
        chk_bit("ibuf_run", 1'b1, ibuf_run);
        chk_bit("boot_mode", 1'b1, boot_mode);
        ibuf_done <= 1'b1;
        @(posedge ref_clk);
        ibuf_done <= 1'b0;
        repeat (3) @(posedge ref_clk);
        chk_bit("ibuf_run", 1'b0, ibuf_run);
        chk_bit("boot_mode", 1'b1, boot_mode);
        $display("test ibuf done");
    endtask

    // leave bootstrap, ignore a stray jump, resume on the fixed one
    task automatic t_user();
        ex_q.delete();
        send_str("0000400000\015");
        chk_val("exec_addr", 32'h00004000, ex_q[0]);
        chk_bit("boot_mode", 1'b0, boot_mode);
        vec_rd <= 1'b1;
        vec_probe(32'h4, 1'b0);
        vec_rd <= 1'b0;
        jump_valid <= 1'b1;
        jump_addr <= 32'h00001000; // stray jump only, loader registers untouched
        @(posedge ref_clk);
        jump_valid <= 1'b0;
        repeat (3) @(posedge ref_clk);
        chk_bit("boot_mode", 1'b0, boot_mode);
        jump_valid <= 1'b1;
        jump_addr <= 32'hFFFFFF44;
        @(posedge ref_clk);
        jump_valid <= 1'b0;
        repeat (3) @(posedge ref_clk);
        chk_bit("boot_mode", 1'b1, boot_mode);
        $display("test user done");
    endtask

    initial begin
        repeat (WATCH) @(posedge ref_clk);
        mismatches++;
        give_verdict();
    end

    initial begin
        sys_rst = 1'b1;
        brk = 1'b0;
        ibuf_done = 1'b0;
        jump_valid = 1'b0;
        jump_addr = 32'h0;
        vec_rd = 1'b0;
        vec_addr = 32'h0;
        repeat (4) @(posedge ref_clk);
        sys_rst <= 1'b0;
        repeat (3) @(posedge ref_clk);
        t_reset();
        t_data();
        t_discard();
        t_ibuf();
        t_user();
        give_verdict();
    end
endmodule
`default_nettype wire
